// ==== core/alu_status_flag_logic.sv ====
// alu status and sticky flag logic for two processing elements
// assumes decode gives one op per cycle and the datapath its raw conditions
//
// What this block does
// - every alu op rewrites seven status flags to show its own result
// - zero flag set on zero result or float underflow, by every op
// - negative flag follows result, forced zero by abs and significand ops
// - carry only from fixed add, sub, carry forms, inc, dec, negate, average
// - input sign captured by abs and significand extract, zero otherwise
// - invalid flag from float-input ops, zero for fixed and int-to-float
// - float op flag written 0 after fixed ops, 1 after float ops
// - compare history changes only on the three compare ops
// - fixed overflow from add, sub, carry forms, inc, dec, neg, abs only
// - float overflow only from the listed float ops, others force zero
// - the four sticky flags are set by ops or a software write, cleared by software
// - fixed overflow sticky set by the fixed overflow ops only
// - float underflow sticky set only by the listed float ops
// - float overflow sticky set only by the listed float ops
// - invalid sticky set by float-input ops, never fixed or int-to-float
// - dual mode runs each op on element y too, with its own registers
// - compare shifts history right, top bit is one when x exceeds y
// - updates show next cycle; a same-cycle register write wins
// - in dual mode condition flags are the or of both elements
// - underflow, overflow or invalid raises an exception request
`include "alu_flag_defines.svh"
module alu_status_flag_logic
   import alu_flag_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   input  wire logic                   op_valid,
   input  wire op_type                 op_code,
   input  wire logic                   dual_mode,
   input  wire raw_type                raw_x,
   input  wire raw_type                raw_y,
   input  wire logic [`REG_ADDR_W-1:0] reg_addr,
   input  wire logic [`REG_DATA_W-1:0] reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [`REG_DATA_W-1:0] reg_rdata,
   output logic      [`REG_DATA_W-1:0] cond_status,
   output logic      [`REG_DATA_W-1:0] cond_sticky,
   output logic                        exception_req
);

   effect_type             eff;
   logic                   upd_x;
   logic                   upd_y;
   logic                   st_we_x;
   logic                   st_we_y;
   logic                   sk_we_x;
   logic                   sk_we_y;
   logic [`REG_DATA_W-1:0] arith_status_pe_x;
   logic [`REG_DATA_W-1:0] arith_status_pe_y;
   logic [`REG_DATA_W-1:0] sticky_status_pe_x;
   logic [`REG_DATA_W-1:0] sticky_status_pe_y;
   logic                   exc_x;
   logic                   exc_y;
   logic [`REG_DATA_W-1:0] rdata_d;
   logic                   exc_d;

   // per-op flag effects
   always_comb begin
      eff = '0;
      case (op_code)
         op_add,
         op_sub,
         op_add_ci,
         op_sub_borrow,
         op_inc_ci,
         op_dec_ci,
         op_inc,
         op_dec,
         op_neg: begin
            eff.ov   = 1'b1;
            eff.neg  = 1'b1;
            eff.cy   = 1'b1;
            eff.s_xv = 1'b1;
         end
         op_avg: begin
            eff.neg = 1'b1;
            eff.cy  = 1'b1;
         end
         op_comp,
         op_unsigned_compare: begin
            eff.neg = 1'b1;
            eff.cmp = 1'b1;
         end
         op_abs: begin
            eff.ov   = 1'b1;
            eff.sgn  = 1'b1;
            eff.s_xv = 1'b1;
         end
         op_pass,
         op_and,
         op_or,
         op_xor,
         op_not,
         op_min,
         op_max,
         op_clip: begin
            eff.neg = 1'b1;
         end
         op_fadd,
         op_fsub: begin
            eff.flt   = 1'b1;
            eff.ov    = 1'b1;
            eff.neg   = 1'b1;
            eff.inv   = 1'b1;
            eff.s_fu  = 1'b1;
            eff.s_fv  = 1'b1;
            eff.s_inv = 1'b1;
         end
         op_fabs_add,
         op_fabs_sub: begin
            eff.flt   = 1'b1;
            eff.ov    = 1'b1;
            eff.inv   = 1'b1;
            eff.s_fu  = 1'b1;
            eff.s_fv  = 1'b1;
            eff.s_inv = 1'b1;
         end
         op_favg: begin
            eff.flt   = 1'b1;
            eff.neg   = 1'b1;
            eff.inv   = 1'b1;
            eff.s_fu  = 1'b1;
            eff.s_inv = 1'b1;
         end
         op_fcomp: begin
            eff.flt   = 1'b1;
            eff.neg   = 1'b1;
            eff.inv   = 1'b1;
            eff.cmp   = 1'b1;
            eff.s_inv = 1'b1;
         end
         op_fneg,
         op_fpass,
         op_sign_transfer,
         op_fmin,
         op_fmax,
         op_fclip: begin
            eff.flt   = 1'b1;
            eff.neg   = 1'b1;
            eff.inv   = 1'b1;
            eff.s_inv = 1'b1;
         end
         op_fabs: begin
            eff.flt   = 1'b1;
            eff.sgn   = 1'b1;
            eff.inv   = 1'b1;
            eff.s_inv = 1'b1;
         end
         op_round_float,
         op_exponent_extract,
         op_inv_sqrt_seed: begin
            eff.flt   = 1'b1;
            eff.ov    = 1'b1;
            eff.neg   = 1'b1;
            eff.inv   = 1'b1;
            eff.s_fv  = 1'b1;
            eff.s_inv = 1'b1;
         end
         op_exponent_scale,
         op_fix_scaled,
         op_fix,
         op_reciprocal_seed: begin
            eff.flt   = 1'b1;
            eff.ov    = 1'b1;
            eff.neg   = 1'b1;
            eff.inv   = 1'b1;
            eff.s_fu  = 1'b1;
            eff.s_fv  = 1'b1;
            eff.s_inv = 1'b1;
         end
         op_significand_extract: begin
            eff.flt   = 1'b1;
            eff.ov    = 1'b1;
            eff.sgn   = 1'b1;
            eff.inv   = 1'b1;
            eff.s_fv  = 1'b1;
            eff.s_inv = 1'b1;
         end
         op_round_toward_zero_convert,
         op_round_toward_zero_convert_scaled: begin
            eff.flt   = 1'b1;
            eff.neg   = 1'b1;
            eff.inv   = 1'b1;
            eff.s_fu  = 1'b1;
            eff.s_inv = 1'b1;
         end
         op_float_scaled: begin
            eff.flt  = 1'b1;
            eff.ov   = 1'b1;
            eff.neg  = 1'b1;
            eff.s_fu = 1'b1;
            eff.s_fv = 1'b1;
         end
         op_float_plain: begin
            eff.flt = 1'b1;
            eff.neg = 1'b1;
         end
         default: begin
            eff = '0;
         end
      endcase
   end

   assign upd_x = op_valid;
   assign upd_y = op_valid & dual_mode;

   // register write decode
   always_comb begin
      st_we_x = 1'b0;
      st_we_y = 1'b0;
      sk_we_x = 1'b0;
      sk_we_y = 1'b0;
      if (reg_wr && reg_addr == `ADDR_STATUS_X) begin
         st_we_x = 1'b1;
      end else if (reg_wr && reg_addr == `ADDR_STATUS_Y) begin
         st_we_y = 1'b1;
      end else if (reg_wr && reg_addr == `ADDR_STICKY_X) begin
         sk_we_x = 1'b1;
      end else if (reg_wr && reg_addr == `ADDR_STICKY_Y) begin
         sk_we_y = 1'b1;
      end
   end

   pe_flag_unit u_pe_x (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .upd      (upd_x),
      .eff      (eff),
      .raw      (raw_x),
      .st_we    (st_we_x),
      .sk_we    (sk_we_x),
      .wdata    (reg_wdata),
      .status_q (arith_status_pe_x),
      .sticky_q (sticky_status_pe_x),
      .exc      (exc_x)
   );

   // second element with its own registers
   pe_flag_unit u_pe_y (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .upd      (upd_y),
      .eff      (eff),
      .raw      (raw_y),
      .st_we    (st_we_y),
      .sk_we    (sk_we_y),
      .wdata    (reg_wdata),
      .status_q (arith_status_pe_y),
      .sticky_q (sticky_status_pe_y),
      .exc      (exc_y)
   );

   // register read, data one cycle after the strobe
   always_comb begin
      rdata_d = `READ_IDLE;
      if (reg_rd && reg_addr == `ADDR_STATUS_X) begin
         rdata_d = arith_status_pe_x;
      end else if (reg_rd && reg_addr == `ADDR_STATUS_Y) begin
         rdata_d = arith_status_pe_y;
      end else if (reg_rd && reg_addr == `ADDR_STICKY_X) begin
         rdata_d = sticky_status_pe_x;
      end else if (reg_rd && reg_addr == `ADDR_STICKY_Y) begin
         rdata_d = sticky_status_pe_y;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         reg_rdata <= `READ_IDLE;
      end else begin
         reg_rdata <= rdata_d;
      end
   end

   // condition view for the sequencer
   always_comb begin
      cond_status = arith_status_pe_x;
      cond_sticky = sticky_status_pe_x;
      if (dual_mode) begin
         cond_status = arith_status_pe_x | arith_status_pe_y;
         cond_sticky = sticky_status_pe_x | sticky_status_pe_y;
      end
   end

   // one-cycle exception request toward interrupt logic
   assign exc_d = exc_x | exc_y;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         exception_req <= 1'b0;
      end else begin
         exception_req <= exc_d;
      end
   end

endmodule : alu_status_flag_logic

// ==== core/alu_flag_defines.svh ====
// register offsets, bit positions and reset values of the alu flag logic
// assumes inclusion by bare name from the design files
`ifndef ALU_FLAG_DEFINES_SVH
`define ALU_FLAG_DEFINES_SVH

`define REG_ADDR_W     4
`define REG_DATA_W     32

`define ADDR_STATUS_X  4'h0
`define ADDR_STATUS_Y  4'h1
`define ADDR_STICKY_X  4'h2
`define ADDR_STICKY_Y  4'h3

`define ZERO_BIT       0
`define OVF_BIT        1
`define NEG_BIT        2
`define CARRY_BIT      3
`define SIGN_BIT       4
`define INV_BIT        5
`define FLOAT_BIT      6
`define HIST_LSB       24
`define HIST_MSB       31

`define FUNF_STKY_BIT  0
`define FOVF_STKY_BIT  1
`define XOVF_STKY_BIT  2
`define INV_STKY_BIT   3

`define STATUS_MASK    32'hff00_007f
`define STICKY_MASK    32'h0000_000f
`define STATUS_RST     32'h0000_0000
`define STICKY_RST     32'h0000_0000
`define READ_IDLE      32'h0000_0000

`endif

// ==== core/alu_flag_pkg.sv ====
// types shared by the alu flag logic and its per-element flag unit
// assumes the datapath supplies raw conditions in the same cycle as the op
package alu_flag_pkg;

   typedef enum logic [5:0] {
      op_add, op_sub, op_add_ci, op_sub_borrow, op_avg,
      op_comp, op_unsigned_compare, op_inc_ci, op_dec_ci,
      op_inc, op_dec, op_neg, op_abs, op_pass,
      op_and, op_or, op_xor, op_not, op_min, op_max, op_clip,
      op_fadd, op_fsub, op_fabs_add, op_fabs_sub, op_favg,
      op_fcomp, op_fneg, op_fabs, op_fpass, op_round_float,
      op_exponent_scale, op_significand_extract, op_exponent_extract,
      op_fix_scaled, op_fix, op_round_toward_zero_convert,
      op_round_toward_zero_convert_scaled, op_float_scaled, op_float_plain,
      op_reciprocal_seed, op_inv_sqrt_seed, op_sign_transfer,
      op_fmin, op_fmax, op_fclip
   } op_type;

   // which flags an op evaluates; unset means forced zero or untouched
   typedef struct packed {
      logic ov;
      logic neg;
      logic cy;
      logic sgn;
      logic inv;
      logic cmp;
      logic flt;
      logic s_fu;
      logic s_fv;
      logic s_xv;
      logic s_inv;
   } effect_type;

   // raw conditions of one element's datapath result
   typedef struct packed {
      logic zero;
      logic negative;
      logic carry;
      logic overflow;
      logic underflow;
      logic invalid;
      logic input_sign;
      logic x_gt_y;
   } raw_type;

endpackage : alu_flag_pkg

// ==== core/pe_flag_unit.sv ====
// status and sticky registers of one processing element
// assumes eff is decoded from the op of the current cycle
`include "alu_flag_defines.svh"
module pe_flag_unit
   import alu_flag_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   input  wire logic                   upd,
   input  wire effect_type             eff,
   input  wire raw_type                raw,
   input  wire logic                   st_we,
   input  wire logic                   sk_we,
   input  wire logic [`REG_DATA_W-1:0] wdata,
   output logic      [`REG_DATA_W-1:0] status_q,
   output logic      [`REG_DATA_W-1:0] sticky_q,
   output logic                        exc
);

   logic [`REG_DATA_W-1:0] status_d;
   logic [`REG_DATA_W-1:0] sticky_d;
   logic [`REG_DATA_W-1:0] set_vec;

   always_comb begin
      status_d = status_q;
      if (st_we) begin
         status_d = wdata & `STATUS_MASK;
      end else if (upd) begin
         status_d[`ZERO_BIT]  = raw.zero | (eff.flt & raw.underflow);
         status_d[`OVF_BIT]   = eff.ov & raw.overflow;
         status_d[`NEG_BIT]   = eff.neg & raw.negative;
         status_d[`CARRY_BIT] = eff.cy & raw.carry;
         status_d[`SIGN_BIT]  = eff.sgn & raw.input_sign;
         status_d[`INV_BIT]   = eff.inv & raw.invalid;
         status_d[`FLOAT_BIT] = eff.flt;
         if (eff.cmp) begin
            status_d[`HIST_MSB:`HIST_LSB] =
               {raw.x_gt_y, status_q[`HIST_MSB:`HIST_LSB+1]};
         end
      end
   end

   always_comb begin
      set_vec = `STICKY_RST;
      set_vec[`FUNF_STKY_BIT] = eff.s_fu & raw.underflow;
      set_vec[`FOVF_STKY_BIT] = eff.s_fv & raw.overflow;
      set_vec[`XOVF_STKY_BIT] = eff.s_xv & raw.overflow;
      set_vec[`INV_STKY_BIT]  = eff.s_inv & raw.invalid;
   end

   always_comb begin
      sticky_d = sticky_q;
      if (sk_we) begin
         sticky_d = wdata & `STICKY_MASK;
      end else if (upd) begin
         sticky_d = sticky_q | set_vec;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         status_q <= `STATUS_RST;
      end else begin
         status_q <= status_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sticky_q <= `STICKY_RST;
      end else begin
         sticky_q <= sticky_d;
      end
   end

   // exception event of this op, before any register override
   assign exc = upd & ((eff.ov & raw.overflow) | (eff.flt & raw.underflow)
                       | (eff.inv & raw.invalid));

endmodule : pe_flag_unit

// ==== verification/alu_flag_checker.sv ====
// assertions on the ports of the alu status flag logic
// assumes one clock domain and a synchronous active-low reset
`include "alu_flag_defines.svh"
module alu_flag_checker
   import alu_flag_pkg::*;
(
   input wire logic                   ref_clk,
   input wire logic                   rst_n,
   input wire logic                   op_valid,
   input wire op_type                 op_code,
   input wire logic                   dual_mode,
   input wire raw_type                raw_x,
   input wire raw_type                raw_y,
   input wire logic [`REG_ADDR_W-1:0] reg_addr,
   input wire logic [`REG_DATA_W-1:0] reg_wdata,
   input wire logic                   reg_wr,
   input wire logic                   reg_rd,
   input wire logic [`REG_DATA_W-1:0] reg_rdata,
   input wire logic [`REG_DATA_W-1:0] cond_status,
   input wire logic [`REG_DATA_W-1:0] cond_sticky,
   input wire logic                   exception_req
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // op on element x alone with no register write beside it
   wire logic solo = op_valid && !dual_mode && !reg_wr;

   chk_exc_has_op: assert property (exception_req |-> $past(op_valid))
      else $error("exception without an op");
   chk_exc_add_ovf: assert property (op_valid && op_code == op_add && raw_x.overflow |=> exception_req)
      else $error("add overflow raised no exception");
   chk_float_flag: assert property (solo |=> cond_status[`FLOAT_BIT] == ($past(op_code) >= op_fadd))
      else $error("float op flag wrong");
   chk_carry_float: assert property (solo && op_code >= op_fadd |=> !cond_status[`CARRY_BIT])
      else $error("carry set by float op");
   chk_sign_forced: assert property (solo && !(op_code inside {op_abs, op_fabs, op_significand_extract})
      |=> !cond_status[`SIGN_BIT])
      else $error("input sign not forced zero");
   chk_inv_fixed: assert property (solo && op_code < op_fadd |=> !cond_status[`INV_BIT])
      else $error("invalid set by fixed op");
   chk_zero_set: assert property (solo && raw_x.zero |=> cond_status[`ZERO_BIT])
      else $error("zero flag missing");
   chk_hist_hold: assert property (solo && !(op_code inside {op_comp, op_unsigned_compare, op_fcomp})
      |=> $stable(cond_status[31:24]))
      else $error("history changed by non-compare");
   chk_hist_shift: assert property (solo && op_code == op_comp
      |=> cond_status[31:24] == {$past(raw_x.x_gt_y), $past(cond_status[31:25])})
      else $error("history shift wrong");
   chk_sticky_keep: assert property (!reg_wr && !dual_mode
      |=> (cond_sticky & $past(cond_sticky)) == $past(cond_sticky))
      else $error("sticky bit cleared by op");
   chk_write_wins: assert property (reg_wr && reg_addr == `ADDR_STATUS_X && !dual_mode
      |=> cond_status == ($past(reg_wdata) & `STATUS_MASK))
      else $error("status write lost");
endmodule : alu_flag_checker

bind alu_status_flag_logic alu_flag_checker u_alu_flag_checker (
   .ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code), .dual_mode(dual_mode),
   .raw_x(raw_x), .raw_y(raw_y), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cond_status(cond_status), .cond_sticky(cond_sticky),
   .exception_req(exception_req));

// ==== verification/op_decoder_model.sv ====
// op source standing in for decode and for the datapath that gives the raw conditions
// assumes its tasks are called right after a rising edge
module op_decoder_model
   import alu_flag_pkg::*;
(
   input  wire logic ref_clk,
   output logic      op_valid,
   output op_type    op_code,
   output raw_type   raw_x,
   output raw_type   raw_y
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      op_valid = 1'b0;
      op_code  = op_add;
      raw_x    = '0;
      raw_y    = '0;
   end
   task automatic start(input op_type o, input raw_type rx, input raw_type ry);
      op_valid <= 1'b1;
      op_code  <= o;
      raw_x    <= rx;
      raw_y    <= ry;
   endtask : start
   // raw lines mean nothing between ops, so scramble them
   task automatic stop();
      op_valid <= 1'b0;
      raw_x    <= ~raw_x;
      raw_y    <= ~raw_y;
   endtask : stop
   task automatic issue(input op_type o, input raw_type rx, input raw_type ry);
      @(posedge ref_clk);
      start(o, rx, ry);
      @(posedge ref_clk);
      stop();
   endtask : issue
endmodule : op_decoder_model

// ==== verification/alu_status_flag_logic_tb.sv ====
// self-checking bench for the alu status and sticky flag logic
// assumes the op source model and the bound checker
`include "alu_flag_defines.svh"
module alu_status_flag_logic_tb
   import alu_flag_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   ref_clk   = 1'b0;
   logic                   rst_n     = 1'b0;
   logic                   dual_mode = 1'b0;
   logic                   reg_wr    = 1'b0;
   logic                   reg_rd    = 1'b0;
   logic [`REG_ADDR_W-1:0] reg_addr  = '0;
   logic [`REG_DATA_W-1:0] reg_wdata = '0;
   logic [`REG_DATA_W-1:0] reg_rdata, cond_status, cond_sticky;
   logic [31:0]            exp_sx, exp_sy, exp_kx, exp_ky;
   logic                   exception_req, op_valid;
   op_type                 op_code;
   raw_type                raw_x, raw_y;
   int                     num_errors = 0;
   int                     cmp_count  = 0;

   always #2.5 ref_clk = ~ref_clk;

   alu_status_flag_logic u_alu_status_flag_logic (
      .ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code), .dual_mode(dual_mode),
      .raw_x(raw_x), .raw_y(raw_y), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cond_status(cond_status), .cond_sticky(cond_sticky),
      .exception_req(exception_req));
   op_decoder_model u_op_decoder_model (
      .ref_clk(ref_clk), .op_valid(op_valid), .op_code(op_code), .raw_x(raw_x), .raw_y(raw_y));

   function automatic effect_type eff_of(input op_type o);
      effect_type e;
      e       = '0;
      e.flt   = (o >= op_fadd);
      e.inv   = e.flt && !(o inside {op_float_scaled, op_float_plain});
      e.s_inv = e.inv;
      e.neg   = !(o inside {op_abs, op_fabs, op_fabs_add, op_fabs_sub, op_significand_extract});
      e.cy    = o inside {op_add, op_sub, op_add_ci, op_sub_borrow, op_avg, op_inc_ci, op_dec_ci, op_inc,
                          op_dec, op_neg};
      e.sgn   = o inside {op_abs, op_fabs, op_significand_extract};
      e.cmp   = o inside {op_comp, op_unsigned_compare, op_fcomp};
      e.ov    = o inside {op_add, op_sub, op_add_ci, op_sub_borrow, op_inc_ci, op_dec_ci, op_inc, op_dec,
                          op_neg, op_abs, op_fadd, op_fsub, op_fabs_add, op_fabs_sub, op_round_float,
                          op_exponent_scale, op_significand_extract, op_exponent_extract, op_fix_scaled,
                          op_fix, op_float_scaled, op_reciprocal_seed, op_inv_sqrt_seed};
      e.s_xv  = e.ov && !e.flt;
      e.s_fv  = e.ov && e.flt;
      e.s_fu  = o inside {op_fadd, op_fsub, op_fabs_add, op_fabs_sub, op_favg, op_exponent_scale,
                          op_fix_scaled, op_fix, op_round_toward_zero_convert, op_round_toward_zero_convert_scaled,
                          op_float_scaled, op_reciprocal_seed};
      return e;
   endfunction : eff_of

   task automatic predict(input op_type o, input raw_type r, inout logic [31:0] st, inout logic [31:0] sk,
                          output logic ex);
      effect_type e;
      e       = eff_of(o);
      st[6:0] = {e.flt, e.inv & r.invalid, e.sgn & r.input_sign, e.cy & r.carry, e.neg & r.negative,
                 e.ov & r.overflow, r.zero | (e.flt & r.underflow)};
      if (e.cmp) begin
         st[31:24] = {r.x_gt_y, st[31:25]};
      end
      sk[3:0] = sk[3:0] | {e.s_inv & r.invalid, e.s_xv & r.overflow, e.s_fv & r.overflow, e.s_fu & r.underflow};
      ex      = (e.ov & r.overflow) | (e.flt & r.underflow) | (e.inv & r.invalid);
   endtask : predict

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read

   task automatic reset_values();
      logic [31:0] d;
      {exp_sx, exp_sy, exp_kx, exp_ky} = '0;
      for (int a = 0; a < 4; a++) begin
         reg_read(a[3:0], d);
         check("reset_reg", d, `STATUS_RST);
      end
   endtask : reset_values

   // every op once, sticky cleared before each so each set shows alone
   task automatic sweep(input raw_type r);
      op_type o;
      logic   ex;
      o = op_add;
      do begin
         reg_write(`ADDR_STICKY_X, 32'h0000_0000);
         exp_kx = '0;
         u_op_decoder_model.issue(o, r, ~r);
         predict(o, r, exp_sx, exp_kx, ex);
         #1;
         check("status_x", cond_status, exp_sx);
         check("sticky_x", cond_sticky, exp_kx);
         check("exc", {31'h0, exception_req}, {31'h0, ex});
         o = o.next();
      end while (o != op_add);
   endtask : sweep

   task automatic dual_run();
      logic [31:0] d;
      logic        ex, ey;
      reg_read(`ADDR_STATUS_Y, d);
      check("status_y_idle", d, exp_sy);
      @(posedge ref_clk);
      dual_mode <= 1'b1;
      u_op_decoder_model.issue(op_sub, 8'h40, 8'h11);
      predict(op_sub, 8'h40, exp_sx, exp_kx, ex);
      predict(op_sub, 8'h11, exp_sy, exp_ky, ey);
      #1;
      check("cond_status", cond_status, exp_sx | exp_sy);
      check("cond_sticky", cond_sticky, exp_kx | exp_ky);
      check("exc_dual", {31'h0, exception_req}, {31'h0, ex | ey});
      reg_read(`ADDR_STATUS_Y, d);
      check("status_y", d, exp_sy);
      reg_read(`ADDR_STICKY_Y, d);
      check("sticky_y", d, exp_ky);
      reg_write(`ADDR_STATUS_Y, 32'hffff_ffff);
      reg_write(`ADDR_STICKY_Y, 32'h0000_0000);
      exp_sy = 32'hffff_ffff & `STATUS_MASK;
      exp_ky = '0;
      reg_read(`ADDR_STATUS_Y, d);
      check("status_y_wr", d, exp_sy);
      reg_read(`ADDR_STICKY_Y, d);
      check("sticky_y_clr", d, exp_ky);
      @(posedge ref_clk);
      dual_mode <= 1'b0;
   endtask : dual_run

   // register write in the op cycle, first to status then to sticky
   task automatic override();
      logic       ex;
      logic [3:0] a;
      for (int i = 0; i < 2; i++) begin
         a = (i == 0) ? `ADDR_STATUS_X : `ADDR_STICKY_X;
         @(posedge ref_clk);
         u_op_decoder_model.start(op_fadd, 8'h18, 8'h18);
         reg_wr    <= 1'b1;
         reg_addr  <= a;
         reg_wdata <= 32'h5a00_00a4;
         @(posedge ref_clk);
         u_op_decoder_model.stop();
         reg_wr <= 1'b0;
         predict(op_fadd, 8'h18, exp_sx, exp_kx, ex);
         if (i == 0) begin
            exp_sx = 32'h5a00_00a4 & `STATUS_MASK;
         end else begin
            exp_kx = 32'h5a00_00a4 & `STICKY_MASK;
         end
         #1;
         check("status_wr", cond_status, exp_sx);
         check("sticky_wr", cond_sticky, exp_kx);
         check("exc_wr", {31'h0, exception_req}, {31'h0, ex});
      end
   endtask : override

   // back to back compares, then a quiet op that must keep the stickies
   task automatic persist();
      logic [31:0] d;
      logic        ex;
      @(posedge ref_clk);
      u_op_decoder_model.start(op_comp, 8'h01, 8'h00);
      @(posedge ref_clk);
      u_op_decoder_model.start(op_fcomp, 8'h04, 8'h00);
      @(posedge ref_clk);
      u_op_decoder_model.stop();
      predict(op_comp, 8'h01, exp_sx, exp_kx, ex);
      predict(op_fcomp, 8'h04, exp_sx, exp_kx, ex);
      #1;
      check("exc_b2b", {31'h0, exception_req}, {31'h0, ex});
      u_op_decoder_model.issue(op_inc, 8'h00, 8'h00);
      predict(op_inc, 8'h00, exp_sx, exp_kx, ex);
      reg_read(`ADDR_STATUS_X, d);
      check("status_hist", d, exp_sx);
      reg_read(`ADDR_STICKY_X, d);
      check("sticky_keep", d, exp_kx);
      reg_write(4'h7, 32'hffff_ffff);
      reg_read(4'h7, d);
      check("unmapped", d, `READ_IDLE);
      reg_read(`ADDR_STATUS_X, d);
      check("status_after", d, exp_sx);
   endtask : persist

   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      reset_values();
      sweep(8'hff);
      sweep(8'h00);
      sweep(8'ha5);
      dual_run();
      override();
      persist();
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      give_verdict();
   end
endmodule : alu_status_flag_logic_tb
